// [src/ccb_top.sv]
// Contact chatter blocker for the binary inputs, with its APB register port.
// Assumes raw contact levels arriving asynchronously on binIn.
//
// Operation
// [R01] Block input when changes exceed permitted count.
// [R02] Zero permitted changes disables chatter blocking.
// [R03] Initial test starts at first activation.
// [R04] Exceeding starts idle minutes, input stays blocked.
// [R05] After idle, subsequent test counts changes again.
// [R06] Clean retest releases; else retry, finally block.
// [R07] Infinite test count never blocks finally.
// [R08] Idle and retest only with nonzero tests.
// [R09] Common criteria, per-input enable.
// [R10] Blocked input gets qualifier plus global flag.
// [R11] Single point holds its pre-block level.
// [R12] Double point shows intermediate while chattering.
// [R13] Protection indications always bypass the filter; a blocked double-point partner still forces them to 00.
// [R14] Shared tick prescaler, per-input interval counters.
`timescale 1ns/1ps
module ccb_top #(
  parameter int unsigned NUM_INPUTS     = 8,
  parameter int unsigned CYCLES_PER_SEC = ccb_pkg::CYC_PER_SEC,
  parameter logic [15:0] PROTECT_MASK   = 16'h0000
) (
  // Clock and reset.
  input  wire logic                    core_clk,
  input  wire logic                    arst_n,
  // APB register port.
  input  wire logic [7:0]              paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Field contacts.
  input  wire logic [NUM_INPUTS-1:0]   binIn,
  // Filtered indications.
  output logic      [NUM_INPUTS-1:0]   indication,
  output logic      [NUM_INPUTS-1:0]   chatterBlockQualifier,
  output logic                         chatterFilterActive,
  output logic                         irq
);

  localparam int unsigned N = NUM_INPUTS;
  localparam int unsigned P = NUM_INPUTS / 2;

  // The pairing of double points and the two interrupt halves need an even count up to 16.
  if (N < 2 || N > 16 || (N % 2) != 0) begin : g_bad_n
    $error("NUM_INPUTS must be even and between 2 and 16");
  end
  if (CYCLES_PER_SEC < 2) begin : g_bad_c
    $error("CYCLES_PER_SEC must be at least 2");
  end

  // Whole registered state of the top level.
  typedef struct packed {
    logic [N-1:0]      sync1;      // First synchroniser stage.
    logic [N-1:0]      sync2;      // Second synchroniser stage.
    ccb_pkg::ccb_cfg_t cfg;        // Common monitoring criteria.
    logic [N-1:0]      chanEn;     // Per-input suppression enable.
    logic [P-1:0]      dblMask;    // Pairs that form double points.
    logic [2*N-1:0]    intStat;    // Sticky events: blocks low, releases high.
    logic [2*N-1:0]    intEn;      // Interrupt enables.
    logic [31:0]       secCnt;     // Cycle count within one second.
    logic [5:0]        minCnt;     // Second count within one minute.
    logic              secTick;    // One-cycle second pulse.
    logic              minTick;    // One-cycle minute pulse.
    logic [N-1:0]      ind;        // Indication outputs.
    logic [N-1:0]      qual;       // Chatter qualifiers.
    logic              filterAct;  // Global chatter flag.
    logic              irq;        // Interrupt line.
    logic              pready;     // APB ready.
    logic              pslverr;    // APB error.
    logic [31:0]       prdata;     // APB read data.
  } ccb_top_st_t;

  ccb_top_st_t  r;        // Registered state.
  ccb_top_st_t  next_r;   // Next state.
  logic [N-1:0] blk;      // Channel blocked flags.
  logic [N-1:0] fin;      // Channel final block flags.
  logic [N-1:0] held;     // Channel substituted levels.
  logic [N-1:0] blkEv;    // Channel block pulses.
  logic [N-1:0] relEv;    // Channel release pulses.
  logic [N-1:0] chanOn;   // Effective per-channel enable.
  logic [31:0]  rdMux;    // Read data before registering.
  logic         mapped;   // Address hits a register.
  logic         wrDone;   // Write takes effect this edge.

  // Protection channels can never be blocked, whatever software writes to the channel enables.
  assign chanOn = r.chanEn & ~PROTECT_MASK[N-1:0];  // [R13] [R09]

  // One channel per input, all sharing the same criteria and ticks.
  for (genvar i = 0; i < N; i++) begin : g_ch
    ccb_channel u_ch (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .level    (r.sync2[i]),
      .secTick  (r.secTick),
      .minTick  (r.minTick),
      .enable   (chanOn[i]),
      .cfg      (r.cfg),  // [R09]
      .blocked  (blk[i]),
      .finalBlk (fin[i]),
      .held     (held[i]),
      .blockEv  (blkEv[i]),
      .relEv    (relEv[i])
    );  // [R14]
  end

  // Address decode and read data selection.
  always_comb begin
    mapped = 1'b1;
    rdMux  = 32'h0000_0000;
    case (paddr)
      ccb_pkg::REG_CFG: begin
        rdMux[ccb_pkg::CFG_PERMIT_LSB +: 8] = r.cfg.permit;
        rdMux[ccb_pkg::CFG_TESTS_LSB +: 8]  = r.cfg.tests;
      end
      ccb_pkg::REG_INIT_T:   rdMux[15:0]    = r.cfg.initSec;
      ccb_pkg::REG_IDLE_T:   rdMux[15:0]    = r.cfg.idleMin;
      ccb_pkg::REG_SUB_T:    rdMux[15:0]    = r.cfg.subSec;
      ccb_pkg::REG_CHAN_EN:  rdMux[N-1:0]   = r.chanEn;
      ccb_pkg::REG_DBL_MASK: rdMux[P-1:0]   = r.dblMask;
      ccb_pkg::REG_BLOCKED:  rdMux[N-1:0]   = blk;
      ccb_pkg::REG_FINAL:    rdMux[N-1:0]   = fin;
      ccb_pkg::REG_RAW:      rdMux[N-1:0]   = r.sync2;
      ccb_pkg::REG_INT_STAT: rdMux[2*N-1:0] = r.intStat;
      ccb_pkg::REG_INT_CLR:  rdMux          = 32'h0000_0000;  // Write-only, reads zero.
      ccb_pkg::REG_INT_EN:   rdMux[2*N-1:0] = r.intEn;
      default:               mapped         = 1'b0;
    endcase
  end

  // Next-state logic of the whole top level.
  always_comb begin
    next_r       = r;
    wrDone       = psel && penable && r.pready && pwrite && mapped;
    // Contacts are asynchronous; only the second stage is read further on.
    next_r.sync1 = binIn;
    next_r.sync2 = r.sync1;

    // Shared prescaler: a second pulse, and a minute pulse every sixty of them.
    next_r.secTick = 1'b0;
    next_r.minTick = 1'b0;
    if (r.secCnt >= CYCLES_PER_SEC - 1) begin  // [R14]
      next_r.secCnt  = 32'h0000_0000;
      next_r.secTick = 1'b1;
      if (r.minCnt >= 6'(ccb_pkg::MIN_S - 1)) begin
        next_r.minCnt  = 6'h00;
        next_r.minTick = 1'b1;
      end else begin
        next_r.minCnt = r.minCnt + 6'h01;
      end
    end else begin
      next_r.secCnt = r.secCnt + 32'h0000_0001;
    end

    // APB: ready one cycle after setup, so every access has no wait state.
    next_r.pready  = psel && !penable && !r.pready;
    next_r.pslverr = psel && !penable && !r.pready && !mapped;
    next_r.prdata  = (psel && !penable) ? rdMux : 32'h0000_0000;

    if (wrDone) begin
      case (paddr)
        ccb_pkg::REG_CFG: begin
          next_r.cfg.permit = pwdata[ccb_pkg::CFG_PERMIT_LSB +: 8];
          next_r.cfg.tests  = pwdata[ccb_pkg::CFG_TESTS_LSB +: 8];
        end
        ccb_pkg::REG_INIT_T:   next_r.cfg.initSec = pwdata[15:0];
        ccb_pkg::REG_IDLE_T:   next_r.cfg.idleMin = pwdata[15:0];
        ccb_pkg::REG_SUB_T:    next_r.cfg.subSec  = pwdata[15:0];
        ccb_pkg::REG_CHAN_EN:  next_r.chanEn      = pwdata[N-1:0];
        ccb_pkg::REG_DBL_MASK: next_r.dblMask     = pwdata[P-1:0];
        ccb_pkg::REG_INT_CLR:  next_r.intStat     = r.intStat & ~pwdata[2*N-1:0];
        ccb_pkg::REG_INT_EN:   next_r.intEn       = pwdata[2*N-1:0];
        default:               next_r.intEn       = r.intEn;  // Read-only registers ignore writes.
      endcase
    end
    // New events are merged after the clear so that a set always wins.
    next_r.intStat = next_r.intStat | {relEv, blkEv};
    next_r.irq     = |(next_r.intStat & next_r.intEn);

    // Substituted indications: held level while blocked, otherwise the live level.
    for (int i = 0; i < N; i++) begin
      next_r.ind[i] = blk[i] ? held[i] : r.sync2[i];  // [R11]
    end
    // A chattering double point shows the intermediate position on both bits.
    for (int p = 0; p < P; p++) begin
      if (r.dblMask[p] && (blk[2*p] || blk[2*p+1])) begin  // [R12]
        next_r.ind[2*p]   = 1'b0;
        next_r.ind[2*p+1] = 1'b0;
      end
    end
    next_r.qual      = blk;   // [R10]
    next_r.filterAct = |blk;  // [R10]
  end

  // State register; the filter starts switched off.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      r                <= '0;
      r.cfg.permit     <= ccb_pkg::RST_CFG[ccb_pkg::CFG_PERMIT_LSB +: 8];
      r.cfg.tests      <= ccb_pkg::RST_CFG[ccb_pkg::CFG_TESTS_LSB +: 8];
      r.cfg.initSec    <= ccb_pkg::RST_TIME;
      r.cfg.idleMin    <= ccb_pkg::RST_TIME;
      r.cfg.subSec     <= ccb_pkg::RST_TIME;
    end else begin
      r <= next_r;
    end
  end

  // All outputs come straight from the state register.
  assign prdata                = r.prdata;
  assign pready                = r.pready;
  assign pslverr               = r.pslverr;
  assign indication            = r.ind;
  assign chatterBlockQualifier = r.qual;
  assign chatterFilterActive   = r.filterAct;
  assign irq                   = r.irq;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  minute_tick_a: assert property (r.minTick |-> r.secTick) // [R14]
    else $error("minute tick not aligned to a second tick");
  qual_track_a: assert property (blk[0] |=> chatterBlockQualifier[0] && chatterFilterActive) // [R10]
    else $error("blocked input lacks qualifier or global flag");
  filter_any_a: assert property (##1 chatterFilterActive == (|chatterBlockQualifier)) // [R10]
    else $error("global flag disagrees with qualifiers");
  held_state_a: assert property (blk[0] && !r.dblMask[0] |=> indication[0] == $past(held[0])) // [R11]
    else $error("blocked single point not held");
  // Every pair is watched, so whichever pair software marks as a double point is covered.
  for (genvar p = 0; p < P; p++) begin : g_mid
    mid_state_a: assert property (r.dblMask[p] && (blk[2*p] || blk[2*p+1])
      |=> indication[2*p+1 -: 2] == 2'b00) // [R12]
      else $error("chattering double point not intermediate");
  end
  // The top input is the one that a protection signal usually occupies.
  prot_bypass_a: assert property (PROTECT_MASK[N-1] |-> !blk[N-1] ##1 indication[N-1] == $past(r.sync2[N-1])) // [R13]
    else $error("protection indication was filtered");

endmodule : ccb_top

// [src/ccb_pkg.sv]
// Shared constants and types of the contact chatter blocker.
// Assumes a single 250 MHz core clock and a 32-bit APB register port.
package ccb_pkg;

  // Clock rate and the tick lengths that the interval timers count in.
  localparam int unsigned CLK_HZ      = 250_000_000;
  localparam int unsigned TICK_S      = 1;               // One timer tick, in seconds.
  localparam int unsigned CYC_PER_SEC = CLK_HZ * TICK_S;  // Cycles per second tick.
  localparam int unsigned MIN_S       = 60;              // Seconds per minute tick.

  // Test count value that means the tests never run out.
  localparam logic [7:0] TESTS_INF = 8'hFF;

  // Register byte offsets.
  localparam logic [7:0] REG_CFG      = 8'h00;
  localparam logic [7:0] REG_INIT_T   = 8'h04;
  localparam logic [7:0] REG_IDLE_T   = 8'h08;
  localparam logic [7:0] REG_SUB_T    = 8'h0C;
  localparam logic [7:0] REG_CHAN_EN  = 8'h10;
  localparam logic [7:0] REG_DBL_MASK = 8'h14;
  localparam logic [7:0] REG_BLOCKED  = 8'h18;
  localparam logic [7:0] REG_FINAL    = 8'h1C;
  localparam logic [7:0] REG_RAW      = 8'h20;
  localparam logic [7:0] REG_INT_STAT = 8'h24;
  localparam logic [7:0] REG_INT_CLR  = 8'h28;
  localparam logic [7:0] REG_INT_EN   = 8'h2C;

  // Field positions of the configuration word.
  localparam int unsigned CFG_PERMIT_LSB = 0;
  localparam int unsigned CFG_TESTS_LSB  = 8;

  // Reset values; a zero permit count leaves the filter off.
  localparam logic [31:0] RST_CFG  = 32'h0000_0000;
  localparam logic [15:0] RST_TIME = 16'h0000;

  // Common monitoring criteria shared by every input.
  typedef struct packed {
    logic [7:0]  permit;   // Permissible state changes.
    logic [7:0]  tests;    // Number of chatter tests.
    logic [15:0] initSec;  // Initial test time, seconds.
    logic [15:0] idleMin;  // Idle time, minutes.
    logic [15:0] subSec;   // Subsequent test time, seconds.
  } ccb_cfg_t;

  // States of one input channel.
  typedef enum logic [2:0] {CH_WAIT, CH_INIT, CH_IDLE, CH_SUB, CH_FINAL} ccb_ch_state_t;

  // Whole state of one input channel.
  typedef struct packed {
    ccb_ch_state_t st;
    logic          prev;     // Level seen last cycle.
    logic          held;     // Level substituted while blocked.
    logic [15:0]   timer;    // Ticks left in the running interval.
    logic [7:0]    changes;  // State changes seen in the test interval.
    logic [7:0]    used;     // Failed subsequent tests so far.
    logic          blockEv;  // One-cycle pulse on blocking.
    logic          relEv;    // One-cycle pulse on release.
  } ccb_ch_t;

endpackage : ccb_pkg

// [src/ccb_channel.sv]
// One input channel of the chatter blocker: counts changes, runs the test
// and idle intervals and decides blocking. Assumes a synchronised level.
`timescale 1ns/1ps
module ccb_channel (
  // Clock and reset.
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  // Timing and configuration.
  input  wire logic             level,
  input  wire logic             secTick,
  input  wire logic             minTick,
  input  wire logic             enable,
  input  wire ccb_pkg::ccb_cfg_t cfg,
  // Results.
  output logic                  blocked,
  output logic                  finalBlk,
  output logic                  held,
  output logic                  blockEv,
  output logic                  relEv
);

  ccb_pkg::ccb_ch_t r;       // Registered channel state.
  ccb_pkg::ccb_ch_t next_r;  // Next channel state.
  logic             edgeSeen;  // Level changed this cycle.
  logic [8:0]       cnt;       // Change count including this cycle.
  logic             exceed;    // Count has gone over the limit.
  logic             active;    // Filter switched on for this input.

  // Decision logic of the channel.
  always_comb begin
    next_r         = r;
    next_r.prev    = level;
    next_r.blockEv = 1'b0;
    next_r.relEv   = 1'b0;
    edgeSeen       = level != r.prev;
    cnt            = {1'b0, r.changes} + {8'h00, edgeSeen};
    exceed         = edgeSeen && (cnt > {1'b0, cfg.permit});
    active         = enable && (cfg.permit != 8'h00);  // [R02]
    case (r.st)
      ccb_pkg::CH_WAIT: begin
        // The first activation opens the initial test interval.
        if (edgeSeen && level) begin  // [R03]
          next_r.st      = ccb_pkg::CH_INIT;
          next_r.timer   = cfg.initSec;
          next_r.changes = 8'h01;
        end
      end
      ccb_pkg::CH_INIT: begin
        if (exceed) begin  // [R01]
          next_r.held    = r.prev;  // [R11]
          next_r.blockEv = 1'b1;
          next_r.used    = 8'h00;
          next_r.timer   = cfg.idleMin;
          // Without any chatter tests there is no idle or retest phase.
          next_r.st      = (cfg.tests == 8'h00) ? ccb_pkg::CH_FINAL : ccb_pkg::CH_IDLE;  // [R08] [R04]
        end else begin
          if (edgeSeen) begin
            next_r.changes = cnt[7:0];
          end
          if (secTick) begin
            next_r.timer = r.timer - 16'h0001;
            if (r.timer <= 16'h0001) begin
              next_r.st = ccb_pkg::CH_WAIT;
            end
          end
        end
      end
      ccb_pkg::CH_IDLE: begin
        // Input stays blocked until the idle minutes run out.
        if (minTick) begin  // [R04]
          next_r.timer = r.timer - 16'h0001;
          if (r.timer <= 16'h0001) begin  // [R05]
            next_r.st      = ccb_pkg::CH_SUB;
            next_r.timer   = cfg.subSec;
            next_r.changes = 8'h00;
          end
        end
      end
      ccb_pkg::CH_SUB: begin
        if (exceed) begin  // [R06]
          next_r.used  = r.used + 8'h01;
          next_r.timer = cfg.idleMin;
          // An infinite test count never ends in a final block.
          if (cfg.tests != ccb_pkg::TESTS_INF && (r.used + 8'h01) >= cfg.tests) begin  // [R07]
            next_r.st = ccb_pkg::CH_FINAL;
          end else begin
            next_r.st = ccb_pkg::CH_IDLE;
          end
        end else begin
          if (edgeSeen) begin
            next_r.changes = cnt[7:0];
          end
          if (secTick) begin
            next_r.timer = r.timer - 16'h0001;
            if (r.timer <= 16'h0001) begin  // [R06]
              next_r.st    = ccb_pkg::CH_WAIT;
              next_r.relEv = 1'b1;
            end
          end
        end
      end
      ccb_pkg::CH_FINAL: begin
        next_r.st = ccb_pkg::CH_FINAL;
      end
      default: begin
        next_r.st = ccb_pkg::CH_WAIT;
      end
    endcase
    // Switching the filter off releases the input at once.
    if (!active) begin  // [R02]
      next_r.st    = ccb_pkg::CH_WAIT;
      next_r.relEv = (r.st == ccb_pkg::CH_IDLE) || (r.st == ccb_pkg::CH_SUB) || (r.st == ccb_pkg::CH_FINAL);
    end
  end

  // State register.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '{st: ccb_pkg::CH_WAIT, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign blocked  = (r.st == ccb_pkg::CH_IDLE) || (r.st == ccb_pkg::CH_SUB) || (r.st == ccb_pkg::CH_FINAL);
  assign finalBlk = r.st == ccb_pkg::CH_FINAL;
  assign held     = r.held;
  assign blockEv  = r.blockEv;
  assign relEv    = r.relEv;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence armed_s;
    enable && cfg.permit != 8'h00;
  endsequence

  pass_off_a: assert property (cfg.permit == 8'h00 |=> r.st == ccb_pkg::CH_WAIT) // [R02]
    else $error("filter not off with zero permit count");
  init_start_a: assert property (armed_s and (r.st == ccb_pkg::CH_WAIT && level && !r.prev)
    |=> r.st == ccb_pkg::CH_INIT) // [R03]
    else $error("initial test not started on activation");
  exceed_blk_a: assert property (armed_s and (r.st == ccb_pkg::CH_INIT && exceed) |=> blocked && r.blockEv) // [R01]
    else $error("input not blocked after too many changes");
  final_zero_a: assert property (armed_s and (r.st == ccb_pkg::CH_INIT && exceed && cfg.tests == 8'h00)
    |=> r.st == ccb_pkg::CH_FINAL) // [R08]
    else $error("zero test count did not block finally");
  idle_hold_a: assert property (armed_s and (r.st == ccb_pkg::CH_IDLE && !minTick) |=> r.st == ccb_pkg::CH_IDLE) // [R04]
    else $error("idle interval left early");
  sub_open_a: assert property (armed_s and (r.st == ccb_pkg::CH_IDLE && minTick && r.timer <= 16'h0001)
    |=> r.st == ccb_pkg::CH_SUB && r.changes == 8'h00) // [R05]
    else $error("subsequent test not opened");
  inf_never_a: assert property (r.st == ccb_pkg::CH_SUB && cfg.tests == ccb_pkg::TESTS_INF
    |=> r.st != ccb_pkg::CH_FINAL) // [R07]
    else $error("final block despite infinite tests");
  release_a: assert property (armed_s and (r.st == ccb_pkg::CH_SUB && !exceed && secTick && r.timer <= 16'h0001)
    |=> r.st == ccb_pkg::CH_WAIT ##0 r.relEv) // [R06]
    else $error("input not released after clean retest");

endmodule : ccb_channel

// [testbench/ccb_contacts.sv]
// Field contact model: drives the raw binary inputs of the chatter blocker.
// Assumes the bench calls it right after a rising edge of the core clock.
`timescale 1ns/1ps
module ccb_contacts (
  // Clock.
  input  wire logic       core_clk,
  // Contact levels.
  output logic      [7:0] binIn
);
  // Every contact rests open until the bench closes it.
  initial binIn = 8'h00;

  // Flip the selected contacts n times, one bounce every gap cycles.
  // Real contacts bounce far slower than the clock, so gap is kept above the synchroniser depth.
  task automatic bounce(input logic [7:0] sel, input int n, input int gap);
    repeat (n) begin
      binIn <= binIn ^ sel;
      repeat (gap) @(posedge core_clk);
    end
  endtask : bounce
endmodule : ccb_contacts

// [testbench/contact_chatter_blocker_test.sv]
// Self-checking bench of the chatter blocker: APB set-up, contact bounce, checks.
// Assumes one second is shortened to ten clock cycles through CYCLES_PER_SEC.
`timescale 1ns/1ps
module contact_chatter_blocker_test;
  // Bench signals.
  logic        core_clk = 1'b0;
  logic        arst_n, psel, penable, pwrite, pready, pslverr, err, chatterFilterActive, irq;
  logic [7:0]  paddr, binIn, indication, chatterBlockQualifier;
  logic [31:0] pwdata, prdata, rd;
  int          fails, checked, cycles;

  // Clock of 4 ns.
  always #2 core_clk = ~core_clk;

  // Short seconds keep idle minutes at 600 cycles; input 7 stands for a protection signal.
  ccb_top #(.NUM_INPUTS(8), .CYCLES_PER_SEC(10), .PROTECT_MASK(16'h0080)) dut (
    .core_clk(core_clk), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .binIn(binIn), .indication(indication), .chatterBlockQualifier(chatterBlockQualifier),
    .chatterFilterActive(chatterFilterActive), .irq(irq));

  // Field contacts.
  ccb_contacts contacts (.core_clk(core_clk), .binIn(binIn));

  // Report the counts and the verdict, then stop.
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // Compare one value; four-state so an unknown never matches.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Read a register and compare it.
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdchk

  // A hang is cut short well above the expected run of about 1650 cycles.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 8000) begin
      fails++;
      tally_and_finish();
    end
  end

  // Main sequence.
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    rdchk(ccb_pkg::REG_CFG, 32'h0000_0000);
    apb(8'h40, 1'b0, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    // Common criteria: 20 s initial, 1 min idle, 3 s retest.
    apb(ccb_pkg::REG_INIT_T, 1'b1, 32'h0000_0014);
    apb(ccb_pkg::REG_IDLE_T, 1'b1, 32'h0000_0001);
    apb(ccb_pkg::REG_SUB_T, 1'b1, 32'h0000_0003);
    apb(ccb_pkg::REG_CHAN_EN, 1'b1, 32'h0000_008D);
    apb(ccb_pkg::REG_DBL_MASK, 1'b1, 32'h0000_0002);
    apb(ccb_pkg::REG_INT_EN, 1'b1, 32'h0000_0105);
    contacts.bounce(8'h08, 1, 8);
    apb(ccb_pkg::REG_CFG, 1'b1, 32'h0000_0102);
    // Three changes on inputs 0, 1, 2 and 7 exceed a permit of two.
    contacts.bounce(8'h87, 3, 4);
    repeat (8) @(posedge core_clk);
    chk(32'(chatterBlockQualifier), 32'h0000_0005);
    chk(32'(chatterFilterActive), 32'h0000_0001);
    chk(32'(indication), 32'h0000_0082);
    chk(32'(irq), 32'h0000_0001);
    rdchk(ccb_pkg::REG_INT_STAT, 32'h0000_0005);
    apb(ccb_pkg::REG_INT_CLR, 1'b1, 32'h0000_0005);
    rdchk(ccb_pkg::REG_INT_STAT, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    // Halfway through the idle minute the block must still stand.
    repeat (300) @(posedge core_clk);
    chk(32'(chatterBlockQualifier), 32'h0000_0005);
    // A quiet retest after the idle minute releases both inputs.
    repeat (450) @(posedge core_clk);
    chk(32'(chatterBlockQualifier), 32'h0000_0000);
    chk(32'(indication), 32'h0000_008F);
    rdchk(ccb_pkg::REG_INT_STAT, 32'h0000_0500);
    chk(32'(irq), 32'h0000_0001);
    // A zero permit lets every change through.
    apb(ccb_pkg::REG_CFG, 1'b1, 32'h0000_0000);
    contacts.bounce(8'h01, 3, 4);
    repeat (8) @(posedge core_clk);
    chk(32'(chatterBlockQualifier), 32'h0000_0000);
    chk(32'(indication), 32'h0000_008E);
    // With no retests allowed the first excess blocks for good.
    apb(ccb_pkg::REG_CFG, 1'b1, 32'h0000_0002);
    contacts.bounce(8'h01, 3, 4);
    repeat (8) @(posedge core_clk);
    rdchk(ccb_pkg::REG_FINAL, 32'h0000_0001);
    repeat (750) @(posedge core_clk);
    chk(32'(chatterBlockQualifier), 32'h0000_0001);
    tally_and_finish();
  end
endmodule : contact_chatter_blocker_test
